// >>> include/lbm_port_defs.vh
`ifndef LBM_PORT_DEFS_VH
`define LBM_PORT_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LBM_OFF_MODE 8'h00
`define LBM_OFF_ARB 8'h04
`define LBM_OFF_ADDR 8'h08
`define LBM_OFF_WDATA 8'h0C
`define LBM_OFF_CMD 8'h10
`define LBM_OFF_RDATA 8'h14
`define LBM_OFF_STAT 8'h18
`define LBM_OFF_IRQ 8'h1C
`define LBM_OFF_MASK 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LBM_MODE_CFG_LSB 0
`define LBM_MODE_CFG_MSB 2
`define LBM_MODE_DIV_LSB 4
`define LBM_MODE_DIV_MSB 5
`define LBM_ARB_MASTER_BIT 0
`define LBM_WDATA_BHE_BIT 16
`define LBM_CMD_GO_BIT 0
`define LBM_CMD_WRITE_BIT 1
`define LBM_IRQ_PERIPH_BIT 0
`define LBM_IRQ_DONE_BIT 1
`define LBM_IRQ_HOLD_BIT 2
`define LBM_IRQ_WIDTH 3

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define LBM_RST_CFG 3'h0
`define LBM_RST_DIV 2'h0
`define LBM_RST_MASTER 1'h1
`define LBM_CFG_MUX 3'h4
`define LBM_CFG_FULL_ADDR 3'h0
`define LBM_RESP_OKAY 2'h0
`define LBM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Clock divide: divisors per code, counted in system periods
// ----------------------------------------------------------------
`define LBM_DIV_CODE0 6'h02
`define LBM_DIV_CODE1 6'h04
`define LBM_DIV_CODE2 6'h08
`define LBM_DIV_CODE3 6'h10

`endif

// >>> rtl/lbm_port.v
// Function
// - Config top bit clear in host mode: data pins form a 16-bit data bus.
// - Config 100 in host mode: data pins carry multiplexed address then data.
// - Split-bus strap set: data pins carry address bits 31 to 16.
// - As arbitration master, hold request low asks the port into hold; device then enters hold.
// - Bus request low while wanting the bus; high again once regained.
// - Arbitration master bit makes hold status pin output, else input.
// - As arbitration master, drive hold status low while in hold.
// - Under external arbiter, hold status high keeps bus undriven.
// - Peripheral select asserted during each local bus access.
// - Address latch strobe floats whenever unused, e.g. split-bus mode.
// - Read, write, upper byte strobes float unless port owns the bus.
// - Ready low inserts wait states until target raises it.
// - Peripheral interrupt input feeds the interrupt status.
// - Local bus clock is system clock divided by two-bit field choice.
// - Local clock high phase lasts half a system clock period.
// - Config 000 in host mode: lower pin group is 16-bit address bus.
`timescale 1ns/1ps
`include "lbm_port_defs.vh"

module lbm_port
(
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // AXI4-Lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Interrupt
  output reg IRQ,
  // Strap
  input wire SPLIT_BUS_MODE_STRAP,
  // Data / upper address pins
  input wire [15:0] LOCAL_DATA_PINS_I,
  output reg [15:0] LOCAL_DATA_PINS_O,
  output reg LOCAL_DATA_PINS_OE,
  // Lower address pins
  output reg [15:0] LOCAL_ADDR_PINS_O,
  output reg [15:0] LOCAL_ADDR_PINS_OE,
  // Arbitration
  input wire BUS_HOLD_REQUEST_IN,
  output reg BUS_REQUEST_OUT_N,
  input wire HOLD_STATUS_PIN_I,
  output reg HOLD_STATUS_PIN_O,
  output reg HOLD_STATUS_PIN_OE,
  // Strobes
  output reg PERIPHERAL_SELECT_OUT_N,
  output reg ADDRESS_LATCH_STROBE_O,
  output reg ADDRESS_LATCH_STROBE_OE,
  output reg READ_STROBE_PIN_N_O,
  output reg WRITE_STROBE_PIN_N_O,
  output reg UPPER_BYTE_ENABLE_PIN_N_O,
  output reg STROBES_OE,
  input wire WAIT_STATE_READY_IN,
  input wire PERIPHERAL_IRQ_IN,
  // Local bus clock
  output reg LOCAL_BUS_CLOCK_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_ARB = 3'h1;
  localparam S_ADDR = 3'h2;
  localparam S_STRB = 3'h3;
  localparam S_DONE = 3'h4;

  reg [2:0] cfg_r;
  reg [1:0] div_r;
  reg master_r;
  reg [31:0] addr_r;
  reg [15:0] wdata_r;
  reg bhe_r;
  reg wr_r;
  reg go_r;
  reg [15:0] rdata_r;
  reg [`LBM_IRQ_WIDTH-1:0] irq_stat_r;
  reg [`LBM_IRQ_WIDTH-1:0] irq_mask_r;
  reg [`LBM_IRQ_WIDTH-1:0] irq_set;
  reg [`LBM_IRQ_WIDTH-1:0] irq_clr;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg in_hold_r;
  reg in_hold_nxt;
  reg split_r;
  reg strap_done_r;
  reg [1:0] fill_r;
  reg [5:0] cnt_r;
  reg [5:0] cnt_max;
  wire tick;

  // Synchronisers: stage 1 is read only by stage 2
  reg [15:0] data_s1_r;
  reg [15:0] data_s2_r;
  reg [4:0] ctl_s1_r;
  reg [4:0] ctl_s2_r;
  wire ready_s = ctl_s2_r[0];
  wire pirq_s = ctl_s2_r[1];
  wire hreq_s = ctl_s2_r[2];
  wire hstat_s = ctl_s2_r[3];
  wire strap_s = ctl_s2_r[4];

  // AXI write side
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_bus_r;
  reg [3:0] wstrb_r;
  wire wr_fire = aw_held_r & w_held_r & ~S_AXI_BVALID;

  // ----------------------------------------------------------------
  // Input synchronisers and strap capture
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      data_s1_r <= 16'h0000;
      data_s2_r <= 16'h0000;
      // Idle pin levels, so no false interrupt or hold follows reset
      ctl_s1_r <= 5'h0D;
      ctl_s2_r <= 5'h0D;
      split_r <= 1'b0;
      strap_done_r <= 1'b0;
      fill_r <= 2'h0;
    end
    else
    begin
      data_s1_r <= LOCAL_DATA_PINS_I;
      data_s2_r <= data_s1_r;
      ctl_s1_r <= {SPLIT_BUS_MODE_STRAP, HOLD_STATUS_PIN_I, BUS_HOLD_REQUEST_IN,
                   PERIPHERAL_IRQ_IN, WAIT_STATE_READY_IN};
      ctl_s2_r <= ctl_s1_r;
      // Strap is taken once, when stage 2 first holds a sampled pin
      fill_r <= {fill_r[0], 1'b1};
      if (!strap_done_r && fill_r[1])
      begin
        split_r <= strap_s;
        strap_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Local bus clock divider
  // ----------------------------------------------------------------
  // CLK runs at twice the system rate, so one CLK high cycle is half
  // a system period; a period of 2n cycles keeps duty at 1/(2n).
  always @*
  begin
    case (div_r)
      2'h0: cnt_max = `LBM_DIV_CODE0 + `LBM_DIV_CODE0 - 6'h01;
      2'h1: cnt_max = `LBM_DIV_CODE1 + `LBM_DIV_CODE1 - 6'h01;
      2'h2: cnt_max = `LBM_DIV_CODE2 + `LBM_DIV_CODE2 - 6'h01;
      default: cnt_max = `LBM_DIV_CODE3 + `LBM_DIV_CODE3 - 6'h01;
    endcase
  end

  assign tick = (cnt_r >= cnt_max);

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r <= 6'h00;
      LOCAL_BUS_CLOCK_OUT <= 1'b0;
    end
    else
    begin
      cnt_r <= tick ? 6'h00 : cnt_r + 6'h01;
      LOCAL_BUS_CLOCK_OUT <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration and bus cycle sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    in_hold_nxt = in_hold_r;
    if (master_r)
    begin
      // Hold is entered only between cycles so a transfer is never cut
      if (!in_hold_r && !hreq_s && (state_r == S_IDLE || state_r == S_ARB))
        in_hold_nxt = 1'b1;
      else if (in_hold_r && hreq_s)
        in_hold_nxt = 1'b0;
    end
    else
      in_hold_nxt = hstat_s;
  end

  always @*
  begin
    state_nxt = state_r;
    if (in_hold_r && (state_r == S_ADDR || state_r == S_STRB))
      state_nxt = S_ARB;
    else if (tick)
    begin
      case (state_r)
        S_IDLE: if (go_r) state_nxt = S_ARB;
        S_ARB: if (!in_hold_r) state_nxt = S_ADDR;
        S_ADDR: state_nxt = S_STRB;
        S_STRB: if (ready_s) state_nxt = S_DONE;
        S_DONE: state_nxt = S_IDLE;
        default: state_nxt = S_IDLE;
      endcase
    end
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= S_IDLE;
      in_hold_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      in_hold_r <= in_hold_nxt;
      if (state_r == S_STRB && state_nxt == S_DONE && !wr_r && !split_r)
        rdata_r <= data_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      LOCAL_DATA_PINS_O <= 16'h0000;
      LOCAL_DATA_PINS_OE <= 1'b0;
      LOCAL_ADDR_PINS_O <= 16'h0000;
      LOCAL_ADDR_PINS_OE <= 16'h0000;
      BUS_REQUEST_OUT_N <= 1'b1;
      HOLD_STATUS_PIN_O <= 1'b1;
      HOLD_STATUS_PIN_OE <= 1'b0;
      PERIPHERAL_SELECT_OUT_N <= 1'b1;
      ADDRESS_LATCH_STROBE_O <= 1'b0;
      ADDRESS_LATCH_STROBE_OE <= 1'b0;
      READ_STROBE_PIN_N_O <= 1'b1;
      WRITE_STROBE_PIN_N_O <= 1'b1;
      UPPER_BYTE_ENABLE_PIN_N_O <= 1'b1;
      STROBES_OE <= 1'b0;
    end
    else
    begin
      BUS_REQUEST_OUT_N <= ~(in_hold_r && state_r == S_ARB);
      HOLD_STATUS_PIN_OE <= master_r;
      HOLD_STATUS_PIN_O <= ~in_hold_r;
      STROBES_OE <= ~in_hold_r;
      ADDRESS_LATCH_STROBE_OE <= ~in_hold_r && cfg_r == `LBM_CFG_MUX && !split_r;
      ADDRESS_LATCH_STROBE_O <= state_r == S_ADDR && cfg_r == `LBM_CFG_MUX && !split_r;
      PERIPHERAL_SELECT_OUT_N <= ~(state_r == S_ADDR || state_r == S_STRB);
      READ_STROBE_PIN_N_O <= ~(state_r == S_STRB && !wr_r);
      WRITE_STROBE_PIN_N_O <= ~(state_r == S_STRB && wr_r);
      UPPER_BYTE_ENABLE_PIN_N_O <= ~((state_r == S_ADDR || state_r == S_STRB) && bhe_r);
      LOCAL_ADDR_PINS_O <= addr_r[15:0];
      if (in_hold_r)
        LOCAL_ADDR_PINS_OE <= 16'h0000;
      else if (split_r || cfg_r == `LBM_CFG_FULL_ADDR)
        LOCAL_ADDR_PINS_OE <= 16'hFFFF;
      else if (!cfg_r[2])
        LOCAL_ADDR_PINS_OE <= 16'h00FF;
      else
        LOCAL_ADDR_PINS_OE <= 16'h0000;
      if (split_r)
      begin
        LOCAL_DATA_PINS_O <= addr_r[31:16];
        LOCAL_DATA_PINS_OE <= ~in_hold_r;
      end
      else if (cfg_r == `LBM_CFG_MUX)
      begin
        // Address phase first, then write data on the same pins
        LOCAL_DATA_PINS_O <= (state_r == S_ADDR) ? addr_r[15:0] : wdata_r;
        LOCAL_DATA_PINS_OE <= ~in_hold_r &&
                              (state_r == S_ADDR || (state_r == S_STRB && wr_r));
      end
      else if (!cfg_r[2])
      begin
        LOCAL_DATA_PINS_O <= wdata_r;
        LOCAL_DATA_PINS_OE <= ~in_hold_r && state_r == S_STRB && wr_r;
      end
      else
      begin
        LOCAL_DATA_PINS_O <= 16'h0000;
        LOCAL_DATA_PINS_OE <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always @*
  begin
    irq_set = {`LBM_IRQ_WIDTH{1'b0}};
    irq_set[`LBM_IRQ_PERIPH_BIT] = pirq_s;
    irq_set[`LBM_IRQ_DONE_BIT] = (state_r == S_DONE) && (state_nxt == S_IDLE);
    irq_set[`LBM_IRQ_HOLD_BIT] = in_hold_nxt && !in_hold_r;
    irq_clr = {`LBM_IRQ_WIDTH{1'b0}};
    if (wr_fire && awaddr_r == `LBM_OFF_IRQ && wstrb_r[0])
      irq_clr = wdata_bus_r[`LBM_IRQ_WIDTH-1:0];
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_stat_r <= {`LBM_IRQ_WIDTH{1'b0}};
      IRQ <= 1'b0;
    end
    else
    begin
      // A set in the clearing cycle survives
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `LBM_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_bus_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      cfg_r <= `LBM_RST_CFG;
      div_r <= `LBM_RST_DIV;
      master_r <= `LBM_RST_MASTER;
      addr_r <= 32'h00000000;
      wdata_r <= 16'h0000;
      bhe_r <= 1'b0;
      wr_r <= 1'b0;
      go_r <= 1'b0;
      irq_mask_r <= {`LBM_IRQ_WIDTH{1'b0}};
    end
    else
    begin
      S_AXI_AWREADY <= ~aw_held_r && ~S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_held_r && ~S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWREADY && S_AXI_AWVALID)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WREADY && S_AXI_WVALID)
      begin
        w_held_r <= 1'b1;
        wdata_bus_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (state_r == S_ARB)
        go_r <= 1'b0;
      if (wr_fire)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `LBM_RESP_OKAY;
        case (awaddr_r)
          `LBM_OFF_MODE:
          begin
            if (wstrb_r[0])
            begin
              cfg_r <= wdata_bus_r[`LBM_MODE_CFG_MSB:`LBM_MODE_CFG_LSB];
              div_r <= wdata_bus_r[`LBM_MODE_DIV_MSB:`LBM_MODE_DIV_LSB];
            end
          end
          `LBM_OFF_ARB: if (wstrb_r[0]) master_r <= wdata_bus_r[`LBM_ARB_MASTER_BIT];
          `LBM_OFF_ADDR:
          begin
            if (wstrb_r[0]) addr_r[7:0] <= wdata_bus_r[7:0];
            if (wstrb_r[1]) addr_r[15:8] <= wdata_bus_r[15:8];
            if (wstrb_r[2]) addr_r[23:16] <= wdata_bus_r[23:16];
            if (wstrb_r[3]) addr_r[31:24] <= wdata_bus_r[31:24];
          end
          `LBM_OFF_WDATA:
          begin
            if (wstrb_r[0]) wdata_r[7:0] <= wdata_bus_r[7:0];
            if (wstrb_r[1]) wdata_r[15:8] <= wdata_bus_r[15:8];
            if (wstrb_r[2]) bhe_r <= wdata_bus_r[`LBM_WDATA_BHE_BIT];
          end
          `LBM_OFF_CMD:
          begin
            // A start while a cycle is under way is dropped
            if (wstrb_r[0] && state_r == S_IDLE && !go_r &&
                wdata_bus_r[`LBM_CMD_GO_BIT])
            begin
              go_r <= 1'b1;
              wr_r <= wdata_bus_r[`LBM_CMD_WRITE_BIT];
            end
          end
          `LBM_OFF_IRQ: ;
          `LBM_OFF_MASK: if (wstrb_r[0]) irq_mask_r <= wdata_bus_r[`LBM_IRQ_WIDTH-1:0];
          `LBM_OFF_RDATA: ;
          `LBM_OFF_STAT: ;
          default: S_AXI_BRESP <= `LBM_RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `LBM_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ~S_AXI_ARREADY && ~S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      if (S_AXI_ARREADY && S_AXI_ARVALID)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `LBM_RESP_OKAY;
        S_AXI_RDATA <= 32'h00000000;
        case (S_AXI_ARADDR)
          `LBM_OFF_MODE: S_AXI_RDATA <= {26'h0, div_r, 1'b0, cfg_r};
          `LBM_OFF_ARB: S_AXI_RDATA <= {31'h0, master_r};
          `LBM_OFF_ADDR: S_AXI_RDATA <= addr_r;
          `LBM_OFF_WDATA: S_AXI_RDATA <= {15'h0, bhe_r, wdata_r};
          `LBM_OFF_CMD: S_AXI_RDATA <= {30'h0, wr_r, go_r || state_r != S_IDLE};
          `LBM_OFF_RDATA: S_AXI_RDATA <= {16'h0, rdata_r};
          `LBM_OFF_STAT: S_AXI_RDATA <= {25'h0, state_r, split_r, ~in_hold_r,
                                         in_hold_r, state_r != S_IDLE};
          `LBM_OFF_IRQ: S_AXI_RDATA <= {29'h0, irq_stat_r};
          `LBM_OFF_MASK: S_AXI_RDATA <= {29'h0, irq_mask_r};
          default: S_AXI_RRESP <= `LBM_RESP_SLVERR;
        endcase
      end
    end
  end

endmodule

// >>> sim/lbm_periph.sv
`timescale 1ns/1ps
module lbm_periph (
  // Clock
  input wire clk,
  // Bus pins
  input wire sel_n,
  input wire rd_n,
  input wire wr_n,
  input wire stb_oe,
  input wire ale,
  input wire ale_oe,
  input wire [15:0] d_o,
  input wire [15:0] a_o,
  // Test controls
  input wire [7:0] waits,
  input wire [15:0] rd_val,
  // Answers and captures
  output wire [15:0] d_i,
  output wire rdy,
  output reg [15:0] ale_adr,
  output reg [15:0] wr_dat,
  output reg [15:0] low_adr,
  output reg [7:0] stb_len
);
  reg [7:0] cnt_r;
  reg [15:0] d_idle_r;
  reg rdy_idle_r;
  wire act = stb_oe && !sel_n && (!rd_n || !wr_n);

  // Target answers from its strobes at once; released lines show the inverse
  assign rdy = act ? (cnt_r >= waits) : rdy_idle_r;
  assign d_i = (act && !rd_n) ? rd_val : d_idle_r;

  initial d_idle_r = 16'h0000;
  initial rdy_idle_r = 1'b1;
  initial cnt_r = 8'h00;

  always @(posedge clk)
  begin
    if (act)
    begin
      cnt_r <= cnt_r + 8'h01;
      stb_len <= cnt_r + 8'h01;
      low_adr <= a_o;
      if (!wr_n)
        wr_dat <= d_o;
    end
    else
      cnt_r <= 8'h00;
    rdy_idle_r <= ~rdy;
    d_idle_r <= ~d_i;
    if (ale && ale_oe)
      ale_adr <= d_o;
  end
endmodule

// >>> sim/lbm_port_props.sv
`timescale 1ns/1ps
module lbm_port_props (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Watched pins
  input wire SPLIT_BUS_MODE_STRAP,
  input wire LOCAL_DATA_PINS_OE,
  input wire BUS_HOLD_REQUEST_IN,
  input wire BUS_REQUEST_OUT_N,
  input wire HOLD_STATUS_PIN_I,
  input wire HOLD_STATUS_PIN_O,
  input wire HOLD_STATUS_PIN_OE,
  input wire PERIPHERAL_SELECT_OUT_N,
  input wire ADDRESS_LATCH_STROBE_O,
  input wire ADDRESS_LATCH_STROBE_OE,
  input wire READ_STROBE_PIN_N_O,
  input wire STROBES_OE,
  input wire WAIT_STATE_READY_IN,
  input wire LOCAL_BUS_CLOCK_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_sel_in_read: assert property (STROBES_OE && !READ_STROBE_PIN_N_O |->
    !PERIPHERAL_SELECT_OUT_N) else $error("select high in read strobe");
  a_local_bus_clock_out_high_one: assert property ($rose(LOCAL_BUS_CLOCK_OUT) |=>
    !LOCAL_BUS_CLOCK_OUT) else $error("local clock high too long");
  a_local_bus_clock_out_low_max: assert property ($fell(LOCAL_BUS_CLOCK_OUT) |->
    ##[1:31] LOCAL_BUS_CLOCK_OUT) else $error("local clock low too long");
  a_ale_mux_addr: assert property (ADDRESS_LATCH_STROBE_OE && ADDRESS_LATCH_STROBE_O |->
    LOCAL_DATA_PINS_OE && !PERIPHERAL_SELECT_OUT_N) else $error("latch strobe off cycle");
  a_split_no_ale: assert property (SPLIT_BUS_MODE_STRAP && $past(SPLIT_BUS_MODE_STRAP, 8) |->
    !ADDRESS_LATCH_STROBE_OE) else $error("latch strobe driven in split mode");
  a_req_in_hold: assert property (!BUS_REQUEST_OUT_N |-> !STROBES_OE)
    else $error("request low while owning bus");
  a_hold_floats: assert property (HOLD_STATUS_PIN_OE && !HOLD_STATUS_PIN_O |->
    !STROBES_OE && !LOCAL_DATA_PINS_OE) else $error("bus driven in hold");
  a_ready_waits: assert property (!WAIT_STATE_READY_IN [*4] ##0
    (STROBES_OE && !READ_STROBE_PIN_N_O) |=> !READ_STROBE_PIN_N_O) else $error("wait ignored");
  a_ext_hold_in: assert property (!HOLD_STATUS_PIN_OE && $rose(HOLD_STATUS_PIN_I) |->
    ##[1:80] !STROBES_OE) else $error("bus kept under external hold");
  a_master_hold: assert property (HOLD_STATUS_PIN_OE && $fell(BUS_HOLD_REQUEST_IN) |->
    ##[1:400] !HOLD_STATUS_PIN_O) else $error("hold not entered");

  c_read: cover property (STROBES_OE && $fell(READ_STROBE_PIN_N_O));
  c_ale: cover property (ADDRESS_LATCH_STROBE_OE && ADDRESS_LATCH_STROBE_O);
  c_req: cover property (!BUS_REQUEST_OUT_N);
endmodule

// >>> sim/tb_lbm_port.sv
`timescale 1ns/1ps
`include "lbm_port_defs.vh"
module tb_lbm_port;
  localparam [15:0] RDV = 16'h5A3C;
  reg CLK = 1'b0;
  reg RST_N = 1'b0;
  reg [7:0] S_AXI_AWADDR = 8'h00;
  reg [7:0] S_AXI_ARADDR = 8'h00;
  reg [31:0] S_AXI_WDATA = 32'h0;
  reg [3:0] S_AXI_WSTRB = 4'hF;
  reg S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  reg S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  reg SPLIT_BUS_MODE_STRAP = 1'b0;
  reg BUS_HOLD_REQUEST_IN = 1'b1;
  reg PERIPHERAL_IRQ_IN = 1'b0;
  reg ext_hold = 1'b0;
  reg [7:0] waits = 8'h00;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [15:0] LOCAL_DATA_PINS_I, LOCAL_DATA_PINS_O, LOCAL_ADDR_PINS_O, LOCAL_ADDR_PINS_OE;
  wire LOCAL_DATA_PINS_OE, BUS_REQUEST_OUT_N, HOLD_STATUS_PIN_I, HOLD_STATUS_PIN_O;
  wire HOLD_STATUS_PIN_OE, PERIPHERAL_SELECT_OUT_N, ADDRESS_LATCH_STROBE_O;
  wire ADDRESS_LATCH_STROBE_OE, READ_STROBE_PIN_N_O, WRITE_STROBE_PIN_N_O;
  wire UPPER_BYTE_ENABLE_PIN_N_O, STROBES_OE, WAIT_STATE_READY_IN, LOCAL_BUS_CLOCK_OUT;
  wire [15:0] d_i, ale_adr, wr_dat, low_adr;
  wire [7:0] stb_len;
  reg [31:0] rdat;
  reg [1:0] rresp;
  integer n_mismatch = 0, cmp_count = 0, cyc = 0, i, hi, per;

  always #25 CLK = ~CLK;
  assign LOCAL_DATA_PINS_I = LOCAL_DATA_PINS_OE ? LOCAL_DATA_PINS_O : d_i;
  assign HOLD_STATUS_PIN_I = HOLD_STATUS_PIN_OE ? HOLD_STATUS_PIN_O : ext_hold;

  lbm_port lbm_port_inst (.*);
  lbm_periph lbm_periph_inst (.clk(CLK), .sel_n(PERIPHERAL_SELECT_OUT_N),
    .rd_n(READ_STROBE_PIN_N_O), .wr_n(WRITE_STROBE_PIN_N_O), .stb_oe(STROBES_OE),
    .ale(ADDRESS_LATCH_STROBE_O), .ale_oe(ADDRESS_LATCH_STROBE_OE), .d_o(LOCAL_DATA_PINS_O),
    .a_o(LOCAL_ADDR_PINS_O), .waits(waits), .rd_val(RDV), .d_i(d_i),
    .rdy(WAIT_STATE_READY_IN), .ale_adr(ale_adr), .wr_dat(wr_dat), .low_adr(low_adr),
    .stb_len(stb_len));

  // ----
  // Bus tasks
  // ----
  task chk(input [8*12:1] nm, input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask

  task axw(input [7:0] a, input [31:0] d);
    reg aw;
    reg w;
  begin
    aw = 1'b1;
    w = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (aw || w)
    begin
      @(posedge CLK);
      if (S_AXI_AWREADY === 1'b1)
        aw = 1'b0;
      if (S_AXI_WREADY === 1'b1)
        w = 1'b0;
      S_AXI_AWVALID <= aw;
      S_AXI_WVALID <= w;
    end
    // Ready raised only after the handshake so it is never set twice in one step
    S_AXI_BREADY <= 1'b1;
    while (S_AXI_BVALID !== 1'b1)
      @(posedge CLK);
    rresp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  end
  endtask

  task axr(input [7:0] a);
  begin
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    @(posedge CLK);
    while (S_AXI_ARREADY !== 1'b1)
      @(posedge CLK);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_RREADY <= 1'b1;
    @(posedge CLK);
    while (S_AXI_RVALID !== 1'b1)
      @(posedge CLK);
    rdat = S_AXI_RDATA;
    rresp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  end
  endtask

  task start(input [31:0] a, input [15:0] d, input wr);
  begin
    axw(`LBM_OFF_ADDR, a);
    axw(`LBM_OFF_WDATA, {15'h0000, 1'b1, d});
    axw(`LBM_OFF_CMD, {30'h00000000, wr, 1'b1});
  end
  endtask

  task finish;
  begin
    rdat = 32'h00000001;
    while (rdat[0] !== 1'b0)
      axr(`LBM_OFF_CMD);
  end
  endtask

  task local_bus_clock_out(output integer h, output integer p);
  begin
    repeat (2)
    begin
      while (LOCAL_BUS_CLOCK_OUT !== 1'b0)
        @(posedge CLK);
      while (LOCAL_BUS_CLOCK_OUT !== 1'b1)
        @(posedge CLK);
    end
    h = 0;
    while (LOCAL_BUS_CLOCK_OUT === 1'b1)
    begin
      @(posedge CLK);
      h = h + 1;
    end
    p = h;
    while (LOCAL_BUS_CLOCK_OUT !== 1'b1)
    begin
      @(posedge CLK);
      p = p + 1;
    end
  end
  endtask

  task conclude;
  begin
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  always @(posedge CLK)
  begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end

  // ----
  // Tests
  // ----
  initial
  begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    axr(`LBM_OFF_ARB);
    chk("arb reset", rdat, 32'h00000001);
    axr(8'h40);
    chk("unmapped", rresp, `LBM_RESP_SLVERR);
    axw(8'h40, 32'h00000000);
    chk("unmapped wr", rresp, `LBM_RESP_SLVERR);
    $display("test registers done");
    start(32'h00001234, 16'hA5C3, 1'b1);
    finish;
    chk("wdata", wr_dat, 16'hA5C3);
    chk("low addr", low_adr, 16'h1234);
    chk("addr oe", LOCAL_ADDR_PINS_OE, 16'hFFFF);
    start(32'h00002468, 16'h0000, 1'b0);
    finish;
    axr(`LBM_OFF_RDATA);
    chk("rdata", rdat[15:0], RDV);
    waits <= 8'h14;
    start(32'h00000100, 16'h0000, 1'b0);
    finish;
    chk("wait len", stb_len > 8'h14, 1'b1);
    waits <= 8'h00;
    $display("test data bus done");
    axw(`LBM_OFF_MODE, {29'h00000000, `LBM_CFG_MUX});
    start(32'h0000BEEF, 16'h0F0F, 1'b1);
    finish;
    chk("ale addr", ale_adr, 16'hBEEF);
    chk("mux data", wr_dat, 16'h0F0F);
    $display("test multiplexed done");
    for (i = 0; i < 4; i = i + 1)
    begin
      axw(`LBM_OFF_MODE, i << 4);
      local_bus_clock_out(hi, per);
      chk("local_bus_clock_out high", hi, 1);
      chk("local_bus_clock_out period", per, 4 << i);
    end
    axw(`LBM_OFF_MODE, 32'h00000000);
    $display("test local clock done");
    axw(`LBM_OFF_IRQ, 32'h00000007);
    axw(`LBM_OFF_MASK, 32'h00000001);
    PERIPHERAL_IRQ_IN <= 1'b1;
    repeat (8) @(posedge CLK);
    chk("irq set", IRQ, 1'b1);
    PERIPHERAL_IRQ_IN <= 1'b0;
    repeat (4) @(posedge CLK);
    axw(`LBM_OFF_IRQ, 32'h00000001);
    repeat (3) @(posedge CLK);
    chk("irq clear", IRQ, 1'b0);
    axw(`LBM_OFF_MASK, 32'h00000000);
    PERIPHERAL_IRQ_IN <= 1'b1;
    repeat (8) @(posedge CLK);
    PERIPHERAL_IRQ_IN <= 1'b0;
    chk("irq masked", IRQ, 1'b0);
    axr(`LBM_OFF_IRQ);
    chk("irq status", rdat[0], 1'b1);
    axw(`LBM_OFF_IRQ, 32'h00000007);
    $display("test interrupt done");
    BUS_HOLD_REQUEST_IN <= 1'b0;
    repeat (40) @(posedge CLK);
    chk("hold ack", HOLD_STATUS_PIN_O, 1'b0);
    chk("hold float", STROBES_OE, 1'b0);
    start(32'h00000777, 16'h1357, 1'b1);
    repeat (40) @(posedge CLK);
    chk("bus request", BUS_REQUEST_OUT_N, 1'b0);
    BUS_HOLD_REQUEST_IN <= 1'b1;
    finish;
    chk("request off", BUS_REQUEST_OUT_N, 1'b1);
    chk("held write", wr_dat, 16'h1357);
    $display("test master hold done");
    axw(`LBM_OFF_ARB, 32'h00000000);
    repeat (2) @(posedge CLK);
    chk("ext input", HOLD_STATUS_PIN_OE, 1'b0);
    ext_hold <= 1'b1;
    start(32'h00000999, 16'h0000, 1'b0);
    repeat (40) @(posedge CLK);
    chk("ext float", STROBES_OE, 1'b0);
    axr(`LBM_OFF_CMD);
    chk("ext busy", rdat[0], 1'b1);
    ext_hold <= 1'b0;
    finish;
    axr(`LBM_OFF_RDATA);
    chk("ext rdata", rdat[15:0], RDV);
    axw(`LBM_OFF_ARB, 32'h00000001);
    $display("test external arbiter done");
    RST_N <= 1'b0;
    SPLIT_BUS_MODE_STRAP <= 1'b1;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    axw(`LBM_OFF_MODE, {29'h00000000, `LBM_CFG_MUX});
    start(32'hC0DE4321, 16'h0000, 1'b1);
    finish;
    chk("split high", wr_dat, 16'hC0DE);
    chk("split low", low_adr, 16'h4321);
    $display("test split bus done");
    conclude;
  end
endmodule

bind lbm_port lbm_port_props lbm_port_props_inst (.CLK, .RST_N, .SPLIT_BUS_MODE_STRAP,
  .LOCAL_DATA_PINS_OE, .BUS_HOLD_REQUEST_IN, .BUS_REQUEST_OUT_N, .HOLD_STATUS_PIN_I,
  .HOLD_STATUS_PIN_O, .HOLD_STATUS_PIN_OE, .PERIPHERAL_SELECT_OUT_N,
  .ADDRESS_LATCH_STROBE_O, .ADDRESS_LATCH_STROBE_OE, .READ_STROBE_PIN_N_O, .STROBES_OE,
  .WAIT_STATE_READY_IN, .LOCAL_BUS_CLOCK_OUT);
